/* File: core/dma_reload_defines.svh */
// constants for the dma reload and request detection block
`ifndef DMA_RELOAD_DEFINES_SVH
`define DMA_RELOAD_DEFINES_SVH
// ==========================================
// register byte offsets
`define OFS_RELOAD_SOURCE_ADDRESS 4'h0
`define OFS_CHANNEL_CONTROL       4'h4
`define OFS_CHANNEL_SOURCE_PTR    4'h8
`define OFS_CHANNEL_STATUS        4'hC
// ==========================================
// channel_control field positions
`define CTL_RELOAD_ENABLE         0
`define CTL_LEVEL_POLARITY        1
`define CTL_EDGE_SELECT           2
`define CTL_OVERRUN_SELECT        3
`define CTL_CHANNEL_ENABLE        4
`define CTL_WIDTH                 5
// ==========================================
// channel_status field positions
`define STS_BUSY                  0
`define STS_ACK                   1
`define STS_REQ_SAMPLE            2
// ==========================================
// reset values
`define RST_RELOAD_SOURCE_ADDRESS 32'h0000_0000
`define RST_CHANNEL_SOURCE_PTR    32'h0000_0000
`define RST_CHANNEL_CONTROL       5'h00
// ==========================================
// bus responses
`define RESP_OKAY                 2'h0
`define RESP_SLVERR               2'h2
`endif

/* File: core/dma_reload_pkg.sv */
// types shared by the dma reload and request detection block
package dma_reload_pkg;
  // request handshake states
  typedef enum logic [1:0] {
    ST_SENSE,
    ST_BUSY,
    ST_ACK
  } req_state_t;
  typedef logic [31:0] word_t;
  typedef logic [1:0]  resp_t;
endpackage

/* File: core/dma_reload_and_request_detect.sv */
// dma channel reload register, request detection and axi4-lite register slave
`include "dma_reload_defines.svh"
module dma_reload_and_request_detect (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite slave
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire dma_reload_pkg::word_t s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output dma_reload_pkg::resp_t      s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output dma_reload_pkg::word_t      s_axi_rdata,
  output dma_reload_pkg::resp_t      s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // external requester
  input  wire logic                  transfer_request_input,
  output logic                       transfer_acknowledge_output,
  // rest of the channel
  output logic                       transfer_start,
  input  wire logic                  transfer_done,
  input  wire logic                  transfer_end,
  output dma_reload_pkg::word_t      channel_source_pointer
);
  import dma_reload_pkg::*;

  // ==========================================
  // register state
  word_t               reload_source_address_ff;  // reload value
  word_t               nxt_reload_source_address;
  word_t               src_ptr_ff;                // channel source pointer
  word_t               nxt_src_ptr;
  logic [`CTL_WIDTH-1:0] channel_control_ff;      // control bits
  logic [`CTL_WIDTH-1:0] nxt_channel_control;

  // ==========================================
  // bus slave state
  logic       aw_held_ff;     // write address captured
  logic       nxt_aw_held;
  logic [3:0] aw_addr_ff;     // captured write address
  logic [3:0] nxt_aw_addr;
  logic       w_held_ff;      // write data captured
  logic       nxt_w_held;
  word_t      w_data_ff;      // captured write data
  word_t      nxt_w_data;
  logic [3:0] w_strb_ff;      // captured byte enables
  logic [3:0] nxt_w_strb;
  logic       bvalid_ff;      // write response pending
  logic       nxt_bvalid;
  resp_t      bresp_ff;       // write response code
  resp_t      nxt_bresp;
  logic       rvalid_ff;      // read data pending
  logic       nxt_rvalid;
  word_t      rdata_ff;       // read data
  word_t      nxt_rdata;
  resp_t      rresp_ff;       // read response code
  resp_t      nxt_rresp;
  logic       do_write;       // both halves of a write present

  // ==========================================
  // request detection state
  req_state_t state_ff;       // handshake state
  req_state_t nxt_state;
  logic       req_prev_ff;    // previous request pin sample
  logic       start_ff;       // one-cycle start to the channel
  logic       nxt_start;
  logic       ack_ff;         // acknowledge pin
  logic       nxt_ack;
  logic       req_active;     // pin at its active level
  logic       req_hit;        // a request is seen this cycle

  // ==========================================
  // write merge: address and data may come in either order
  function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] be);
    word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================
  // bus slave next state
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_held  = w_held_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    do_write    = aw_held_ff && w_held_ff && !bvalid_ff;
    // capture address
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    // capture data
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_held = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    // commit write and raise response
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      case (aw_addr_ff)
        `OFS_RELOAD_SOURCE_ADDRESS,
        `OFS_CHANNEL_CONTROL,
        `OFS_CHANNEL_SOURCE_PTR,
        `OFS_CHANNEL_STATUS: nxt_bresp = `RESP_OKAY;
        default:             nxt_bresp = `RESP_SLVERR;
      endcase
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    // read: answer one cycle after address taken
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = `RESP_OKAY;
      case (s_axi_araddr)
        `OFS_RELOAD_SOURCE_ADDRESS: nxt_rdata = reload_source_address_ff;
        `OFS_CHANNEL_CONTROL:       nxt_rdata = {27'h0, channel_control_ff};
        `OFS_CHANNEL_SOURCE_PTR:    nxt_rdata = src_ptr_ff;
        `OFS_CHANNEL_STATUS: begin
          nxt_rdata = 32'h0;
          nxt_rdata[`STS_BUSY]       = (state_ff != ST_SENSE);
          nxt_rdata[`STS_ACK]        = ack_ff;
          nxt_rdata[`STS_REQ_SAMPLE] = req_prev_ff;
        end
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // bus handshake outputs
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready  = !w_held_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // ==========================================
  // register file next state
  always_comb begin
    nxt_reload_source_address = reload_source_address_ff;
    nxt_channel_control       = channel_control_ff;
    nxt_src_ptr               = src_ptr_ff;
    // transfer end reloads only when enabled, else pointer untouched
    if (transfer_end && channel_control_ff[`CTL_RELOAD_ENABLE]) begin
      nxt_src_ptr = reload_source_address_ff;
    end
    // software writes take effect any time; a source pointer write overrides a reload in the same cycle
    if (do_write) begin
      case (aw_addr_ff)
        `OFS_RELOAD_SOURCE_ADDRESS: begin
          nxt_reload_source_address =
            merge(reload_source_address_ff, w_data_ff, w_strb_ff);
        end
        `OFS_CHANNEL_CONTROL: begin
          if (w_strb_ff[0]) begin
            nxt_channel_control = w_data_ff[`CTL_WIDTH-1:0];
          end
        end
        `OFS_CHANNEL_SOURCE_PTR: begin
          nxt_src_ptr = merge(src_ptr_ff, w_data_ff, w_strb_ff);
        end
        default: begin
          nxt_src_ptr = nxt_src_ptr;
        end
      endcase
    end
  end

  assign channel_source_pointer = src_ptr_ff;

  // ==========================================
  // request detection next state
  always_comb begin
    nxt_state = state_ff;
    nxt_start = 1'b0;
    nxt_ack   = 1'b0;
    // polarity bit picks the active level
    req_active = (transfer_request_input == channel_control_ff[`CTL_LEVEL_POLARITY]);
    // edge mode needs the pin inactive in the previous cycle
    if (channel_control_ff[`CTL_EDGE_SELECT]) begin
      req_hit = req_active &&
                (req_prev_ff != channel_control_ff[`CTL_LEVEL_POLARITY]);
    end else begin
      req_hit = req_active;
    end
    // no data path is examined: any requester may drive the pin
    req_hit = req_hit && channel_control_ff[`CTL_CHANNEL_ENABLE];
    case (state_ff)
      // sensitive: accept a request
      ST_SENSE: begin
        if (req_hit) begin
          nxt_state = ST_BUSY;
          nxt_start = 1'b1;
        end
      end
      // blind until the transfer finishes
      ST_BUSY: begin
        if (transfer_done) begin
          nxt_state = ST_ACK;
          nxt_ack   = 1'b1;
        end
      end
      // acknowledge cycle
      ST_ACK: begin
        if (!channel_control_ff[`CTL_EDGE_SELECT] &&
            channel_control_ff[`CTL_OVERRUN_SELECT] && req_hit) begin
          // level still seen with the acknowledge: one extra transfer
          nxt_state = ST_BUSY;
          nxt_start = 1'b1;
        end else begin
          // resample only after the acknowledge has gone
          nxt_state = ST_SENSE;
        end
      end
      default: begin
        nxt_state = ST_SENSE;
      end
    endcase
  end

  assign transfer_start              = start_ff;
  assign transfer_acknowledge_output = ack_ff;

  // ==========================================
  // all registers; reload value has no standby clear path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_source_address_ff <= `RST_RELOAD_SOURCE_ADDRESS;
      src_ptr_ff               <= `RST_CHANNEL_SOURCE_PTR;
      channel_control_ff       <= `RST_CHANNEL_CONTROL;
      aw_held_ff               <= 1'b0;
      aw_addr_ff               <= 4'h0;
      w_held_ff                <= 1'b0;
      w_data_ff                <= 32'h0;
      w_strb_ff                <= 4'h0;
      bvalid_ff                <= 1'b0;
      bresp_ff                 <= `RESP_OKAY;
      rvalid_ff                <= 1'b0;
      rdata_ff                 <= 32'h0;
      rresp_ff                 <= `RESP_OKAY;
      state_ff                 <= ST_SENSE;
      req_prev_ff              <= 1'b0;
      start_ff                 <= 1'b0;
      ack_ff                   <= 1'b0;
    end else begin
      reload_source_address_ff <= nxt_reload_source_address;
      src_ptr_ff               <= nxt_src_ptr;
      channel_control_ff       <= nxt_channel_control;
      aw_held_ff               <= nxt_aw_held;
      aw_addr_ff               <= nxt_aw_addr;
      w_held_ff                <= nxt_w_held;
      w_data_ff                <= nxt_w_data;
      w_strb_ff                <= nxt_w_strb;
      bvalid_ff                <= nxt_bvalid;
      bresp_ff                 <= nxt_bresp;
      rvalid_ff                <= nxt_rvalid;
      rdata_ff                 <= nxt_rdata;
      rresp_ff                 <= nxt_rresp;
      state_ff                 <= nxt_state;
      req_prev_ff              <= transfer_request_input;
      start_ff                 <= nxt_start;
      ack_ff                   <= nxt_ack;
    end
  end
endmodule

/* File: bench/dma_reload_monitor.sv */
// assertion checker bound to the dma reload and request detect block
module dma_reload_monitor (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  transfer_start,
  input wire logic                  transfer_done,
  input wire logic                  transfer_end,
  input wire logic                  transfer_acknowledge_output,
  input wire dma_reload_pkg::word_t channel_source_pointer
);
  timeunit 1ns;
  timeprecision 100ps;
  import dma_reload_pkg::*;
  logic busy_ff;      // a request sits between start and acknowledge
  logic nxt_busy_ff;  // next busy value
  // ==========
  // busy tracking, set by start and cleared by acknowledge
  always_comb begin
    nxt_busy_ff = busy_ff;
    if (transfer_acknowledge_output) nxt_busy_ff = 1'h0;
    if (transfer_start) nxt_busy_ff = 1'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_ff <= 1'h0;
    else busy_ff <= nxt_busy_ff;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========
  // request handshake
  a_start_lone: assert property (transfer_start |=> (!transfer_start) [*2])
    else $error("start pulses too close");
  a_blind_busy: assert property (
    busy_ff && !transfer_acknowledge_output |-> !transfer_start)
    else $error("start while busy");
  a_ack_cause: assert property (transfer_acknowledge_output |-> $past(transfer_done))
    else $error("ack without done");
  a_done_ack: assert property (transfer_done && busy_ff |=> transfer_acknowledge_output)
    else $error("done not acknowledged");
  a_ack_pulse: assert property (
    transfer_acknowledge_output |=> !transfer_acknowledge_output)
    else $error("ack longer than one cycle");
  // ==========
  // register bus and pointer
  a_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_ptr_cause: assert property (
    $changed(channel_source_pointer) |-> $past(transfer_end) || $past(s_axi_wvalid)
    || $past(s_axi_wvalid, 2) || !$past(aresetn))
    else $error("pointer changed without cause");
  c_ack: cover property (transfer_acknowledge_output);
  c_restart: cover property (transfer_acknowledge_output ##1 transfer_start);
  c_end: cover property (transfer_end);
endmodule
bind dma_reload_and_request_detect dma_reload_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .transfer_start(transfer_start), .transfer_done(transfer_done),
  .transfer_end(transfer_end), .transfer_acknowledge_output(transfer_acknowledge_output),
  .channel_source_pointer(channel_source_pointer)
);

/* File: bench/dma_requester_model.sv */
// external requester and channel stand-in: posts requests, answers starts
module dma_requester_model (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       polarity,    // active level of the request pin
  input wire logic [3:0] add_req,     // requests posted this cycle
  input wire logic [3:0] done_delay,  // cycles from start to done, at least 1
  input wire logic       start,
  input wire logic       ack,
  output logic           req_pin,
  output logic           done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] pend_ff;      // requests not yet acknowledged
  logic [3:0] nxt_pend_ff;  // next pending count
  logic [3:0] wait_ff;      // cycles left until done
  logic [3:0] nxt_wait_ff;  // next wait count
  // ==========
  // pin held active until every request is acknowledged
  always_comb begin
    nxt_pend_ff = pend_ff + add_req;
    if (ack && pend_ff != 4'h0) nxt_pend_ff = nxt_pend_ff - 4'h1;
    nxt_wait_ff = (wait_ff != 4'h0) ? wait_ff - 4'h1 : 4'h0;
    if (start) nxt_wait_ff = done_delay;
  end
  always_ff @(posedge aclk) begin
    pend_ff <= aresetn ? nxt_pend_ff : 4'h0;
    wait_ff <= aresetn ? nxt_wait_ff : 4'h0;
  end
  assign req_pin = (pend_ff != 4'h0) ? polarity : ~polarity;
  assign done = (wait_ff == 4'h1);
endmodule

/* File: bench/dma_reload_and_request_detect_bench.sv */
// self-checking bench for the dma reload and request detect block
`include "dma_reload_defines.svh"
module dma_reload_and_request_detect_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dma_reload_pkg::*;
  typedef struct packed {logic [3:0] a; word_t d; word_t e;} reg_row_t;
  typedef struct packed {logic [4:0] c; logic [3:0] n; logic [3:0] d; logic [3:0] e;} req_row_t;
  logic       aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic       s_axi_arvalid = 1'h0, transfer_end = 1'h0, req_pol = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, add_req = 4'h0, dly = 4'h1;
  word_t      s_axi_wdata = 32'h0, s_axi_rdata, ptr;
  resp_t      s_axi_bresp, s_axi_rresp;
  logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic       pin, ack, start, done;
  int         fail_count = 0, num_checks = 0, n_start = 0, n_ack = 0;
  reg_row_t   regs [5] = '{'{4'h0, 32'hA5A5_5A50, 32'hA5A5_5A50}, '{4'h0, 32'h0, 32'h0},
    '{4'h8, 32'h1234_5670, 32'h1234_5670}, '{4'h4, 32'hFFFF_FFFF, 32'h1F}, '{4'h4, 32'h0, 32'h0}};
  // control value, requests, done delay, expected starts
  req_row_t   reqs [8] = '{'{5'h10, 4'h1, 4'h1, 4'h1}, '{5'h14, 4'h1, 4'h3, 4'h1},
    '{5'h12, 4'h1, 4'h1, 4'h1}, '{5'h16, 4'h1, 4'h6, 4'h1}, '{5'h12, 4'h3, 4'h1, 4'h3},
    '{5'h1A, 4'h3, 4'h5, 4'h4}, '{5'h1E, 4'h1, 4'h1, 4'h1}, '{5'h02, 4'h1, 4'h1, 4'h0}};
  // ==========
  // design and far side
  dma_reload_and_request_detect i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(1'h1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'h1), .transfer_request_input(pin),
    .transfer_acknowledge_output(ack), .transfer_start(start), .transfer_done(done),
    .transfer_end(transfer_end), .channel_source_pointer(ptr));
  dma_requester_model i_req (.aclk(aclk), .aresetn(aresetn), .polarity(req_pol),
    .add_req(add_req), .done_delay(dly), .start(start), .ack(ack), .req_pin(pin), .done(done));
  // ==========
  // clock, start counter, watchdog
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (start === 1'h1) n_start++;
  always @(posedge aclk) if (ack === 1'h1) n_ack++;
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    tally_and_finish();
  end
  // ==========
  // shared tasks
  // write with both channels offered together, held until each is taken
  task automatic axi_write(input logic [3:0] a, input word_t d, input resp_t er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    num_checks++;
    if (s_axi_bresp !== er) begin
      fail_count++;
      $display("ERROR %0t write response", $time);
    end
  endtask
  task automatic axi_read(input logic [3:0] a, input word_t ed);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    num_checks++;
    if (s_axi_rdata !== ed || s_axi_rresp !== `RESP_OKAY) begin
      fail_count++;
      $display("ERROR %0t read data", $time);
    end
  endtask
  // program with channel off, set pin sense from the polarity bit, write the full control value, post requests, count starts
  task automatic run_req(input req_row_t r);
    int s0;
    int a0;
    axi_write(`OFS_CHANNEL_CONTROL, {27'h0, r.c & 5'h0F}, `RESP_OKAY);
    req_pol <= r.c[1];
    dly <= r.d;
    axi_write(`OFS_CHANNEL_CONTROL, {27'h0, r.c}, `RESP_OKAY);
    s0 = n_start;
    a0 = n_ack;
    add_req <= r.n;
    @(posedge aclk);
    add_req <= 4'h0;
    repeat (80) @(posedge aclk);
    num_checks += 2;
    if (n_start - s0 != int'(r.e)) begin
      fail_count++;
      $display("ERROR %0t transfer count", $time);
    end
    if (n_ack - a0 != int'(r.e)) begin
      fail_count++;
      $display("ERROR %0t acknowledge count", $time);
    end
  endtask
  task automatic end_pulse();
    transfer_end <= 1'h1;
    @(posedge aclk);
    transfer_end <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    int s0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 3; i++) axi_read(4'(4 * i), 32'h0);
    foreach (regs[i]) begin
      axi_write(regs[i].a, regs[i].d, `RESP_OKAY);
      axi_read(regs[i].a, regs[i].e);
    end
    // unmapped word: refused and nothing written
    axi_write(4'h2, 32'hFFFF_FFFF, `RESP_SLVERR);
    axi_read(`OFS_RELOAD_SOURCE_ADDRESS, 32'h0);
    foreach (reqs[i]) run_req(reqs[i]);
    axi_write(`OFS_RELOAD_SOURCE_ADDRESS, 32'h0000_2000, `RESP_OKAY);
    axi_write(`OFS_CHANNEL_CONTROL, 32'h1, `RESP_OKAY);
    end_pulse();
    axi_read(`OFS_CHANNEL_SOURCE_PTR, 32'h0000_2000);
    num_checks++;
    if (ptr !== 32'h0000_2000) begin
      fail_count++;
      $display("ERROR %0t source pointer output", $time);
    end
    axi_write(`OFS_RELOAD_SOURCE_ADDRESS, 32'h0000_3000, `RESP_OKAY);
    axi_read(`OFS_CHANNEL_SOURCE_PTR, 32'h0000_2000);
    axi_write(`OFS_CHANNEL_CONTROL, 32'h0, `RESP_OKAY);
    end_pulse();
    axi_read(`OFS_CHANNEL_SOURCE_PTR, 32'h0000_2000);
    axi_write(`OFS_CHANNEL_CONTROL, 32'h1, `RESP_OKAY);
    end_pulse();
    axi_read(`OFS_CHANNEL_SOURCE_PTR, 32'h0000_3000);
    // pin held active by the unserved request, channel idle
    axi_read(`OFS_CHANNEL_STATUS, 32'h1 << `STS_REQ_SAMPLE);
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axi_read(`OFS_RELOAD_SOURCE_ADDRESS, 32'h0);
    // rising edge mode: a second edge inside the blind period is dropped
    dly <= 4'h6;
    axi_write(`OFS_CHANNEL_CONTROL, 32'h16, `RESP_OKAY);
    s0 = n_start;
    add_req <= 4'h1;
    @(posedge aclk);
    add_req <= 4'h0;
    repeat (2) @(posedge aclk);
    req_pol <= 1'h0;
    @(posedge aclk);
    req_pol <= 1'h1;
    repeat (40) @(posedge aclk);
    num_checks++;
    if (n_start - s0 != 1) begin
      fail_count++;
      $display("ERROR %0t edge counted while blind", $time);
    end
    tally_and_finish();
  end
endmodule
